// *** src/hlc_consts.svh ***
`ifndef HLC_CONSTS_SVH
`define HLC_CONSTS_SVH
// Register byte offsets.
`define HLC_OFS_CTRL 8'h00
`define HLC_OFS_LIMIT 8'h04
`define HLC_OFS_KNEE 8'h08
`define HLC_OFS_MAXATT 8'h0C
`define HLC_OFS_HEADROOM 8'h10
`define HLC_OFS_VMPO 8'h14
`define HLC_OFS_ATPO 8'h18
`define HLC_OFS_QUOT 8'h1C
`define HLC_OFS_RATIO 8'h20
`define HLC_OFS_ATTEN 8'h24
// Field positions.
`define HLC_CTRL_TYPE_BIT 0
`define HLC_CTRL_EN_BIT 1
// Reset values.
`define HLC_RST_CTRL 2'h0
`define HLC_RST_DB4 4'h0
`define HLC_RST_MAXATT 4'hE
`define HLC_RST_HEADROOM 5'h00
`define HLC_RST_VMPO 12'hFFF
// Arithmetic constants: one dB is 64 steps, headroom is in 2.5 percent steps of 1/40.
`define HLC_DB_ONE 16'h0040
`define HLC_HR_FULL 6'h28
`define HLC_HR_MAX 5'h08
`define HLC_LOG_DB_MUL 9'h181
`define HLC_LOG_TOP 5'h17
`define HLC_DIV_STEPS 5'h10
`endif

// *** src/hlc_pkg.sv ***
package hlc_pkg;
  // Level in dB, signed, 1/64 dB per step.
  typedef logic signed [15:0] hlc_db_t;
  // Sequencer that keeps the compressor quotient and ratio fresh.
  typedef enum logic [1:0] {HLC_Q_START, HLC_Q_WAIT, HLC_R_START, HLC_R_WAIT} hlc_seq_e;
endpackage

// *** src/hlc_level_log.sv ***
`timescale 1ns/10ps
`include "hlc_consts.svh"
module hlc_level_log
  import hlc_pkg::*;
(
  // Magnitude in, dB relative to full scale of 2^23 out.
  input wire logic [23:0] mag,
  output hlc_db_t level_db
);
  logic [4:0] pos;
  logic [23:0] norm;
  logic signed [17:0] log2_q;
  logic signed [27:0] prod;

  // Leading one gives the integer log, the next six bits a linear fraction.
  always_comb
  begin
    pos = 5'h00;
    for (int i = 0; i < 24; i++)
    begin
      if (mag[i])
        pos = 5'(i);
    end
  end

  assign norm = mag << (`HLC_LOG_TOP - pos);
  assign log2_q = $signed({7'h00, pos, norm[22:17]}) - $signed({7'h00, `HLC_LOG_TOP, 6'h00});
  assign prod = log2_q * $signed({1'b0, `HLC_LOG_DB_MUL});
  // Zero has no log; report the floor so it never crosses any knee.
  assign level_db = (mag == 24'h000000) ? 16'sh8001 : prod[21:6];
endmodule

// *** src/hlc_divider.sv ***
`timescale 1ns/10ps
`include "hlc_consts.svh"
module hlc_divider
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Request.
  input wire logic start,
  input wire logic [15:0] num,
  input wire logic [15:0] den,
  // Answer.
  output logic done,
  output logic [15:0] quot
);
  logic [16:0] rem;
  logic [15:0] shf;
  logic [4:0] cnt;
  logic [16:0] trial;

  assign trial = {rem[15:0], shf[15]} - {1'b0, den};

  // Restoring division, one quotient bit a cycle; divide by zero saturates.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rem <= 17'h00000;
      shf <= 16'h0000;
      cnt <= 5'h00;
      done <= 1'b0;
      quot <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        rem <= 17'h00000;
        shf <= num;
        cnt <= `HLC_DIV_STEPS;
      end
      else if (cnt != 5'h00)
      begin
        cnt <= cnt - 5'h01;
        rem <= trial[16] ? {rem[15:0], shf[15]} : trial;
        shf <= {shf[14:0], ~trial[16]};
        if (cnt == 5'h01)
        begin
          done <= 1'b1;
          quot <= (den == 16'h0000) ? 16'hFFFF : {shf[14:0], ~trial[16]};
        end
      end
    end
  end
endmodule

// *** src/hlc_core.sv ***
// Operation
// - Fixed limiter is infinite ratio; threshold 0 to -15 dBFS equals its knee.
// - Limiter peak voltage is max peak voltage times ten to threshold over 20.
// - Below fixed threshold unchanged; above, attenuation is knee minus input level.
// - Above fixed threshold output holds at limiter voltage for any supply.
// - Low supply: no limiting before fixed knee, then limiting stops worse clipping.
// - Compressor knee selectable 0 to -15 dBFS, fixed relative to full scale.
// - Compressor voltage threshold is max peak voltage times ten to knee over 20.
// - Below knee unchanged; above knee ratio recomputed continuously from supply.
// - Compression ratio is knee over target attenuation minus knee, in dB.
// - Compressor attenuation is target minus input times target over knee.
// - Combined: compress first, then limit; may reach full scale unlimited.
// - Target attenuation clamps to 0 dB, so only attenuation is applied.
// - Target peak is supply times one minus headroom, +20 to -20 percent.
// - Applied attenuation never exceeds programmed maximum, -1 to -15 dB.
// - Type select low makes the limiter threshold track the target peak.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "hlc_consts.svh"
module hlc_core
  import hlc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Incoming audio samples.
  input wire logic in_valid,
  input wire logic signed [23:0] in_sample,
  // Supply measurement, already on this clock.
  input wire logic [11:0] supply_code,
  // Towards the amplifier gain path.
  output logic out_valid,
  output logic signed [23:0] out_sample,
  output logic [9:0] out_atten
);

  // ==========================================================
  // Configuration registers
  // ==========================================================
  logic limiter_type_select;
  logic engine_enable;
  logic [3:0] level_limit_threshold;
  logic [3:0] compressor_knee_point;
  logic [3:0] max_attenuation_setting;
  logic signed [4:0] supply_headroom_setting;
  logic [11:0] peak_out_code;

  // Decoded strobes, one per writable register.
  logic wr_ctrl;
  logic wr_limit;
  logic wr_knee;
  logic wr_maxatt;
  logic wr_hr;
  logic wr_vmpo;

  assign wr_ctrl = reg_wr && (reg_addr == `HLC_OFS_CTRL);
  assign wr_limit = reg_wr && (reg_addr == `HLC_OFS_LIMIT);
  assign wr_knee = reg_wr && (reg_addr == `HLC_OFS_KNEE);
  assign wr_maxatt = reg_wr && (reg_addr == `HLC_OFS_MAXATT);
  assign wr_hr = reg_wr && (reg_addr == `HLC_OFS_HEADROOM);
  assign wr_vmpo = reg_wr && (reg_addr == `HLC_OFS_VMPO);

  // Software writes; the maximum code 15 is folded onto 14 so it stays in range.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      limiter_type_select <= 1'b0;
      engine_enable <= 1'b0;
      level_limit_threshold <= `HLC_RST_DB4;
      compressor_knee_point <= `HLC_RST_DB4;
      max_attenuation_setting <= `HLC_RST_MAXATT;
      supply_headroom_setting <= `HLC_RST_HEADROOM;
      peak_out_code <= `HLC_RST_VMPO;
    end
    else
    begin
      if (wr_ctrl)
      begin
        limiter_type_select <= reg_wdata[`HLC_CTRL_TYPE_BIT];
        engine_enable <= reg_wdata[`HLC_CTRL_EN_BIT];
      end
      if (wr_limit)
        level_limit_threshold <= reg_wdata[3:0];
      if (wr_knee)
        compressor_knee_point <= reg_wdata[3:0];
      if (wr_maxatt)
        max_attenuation_setting <= (reg_wdata[3:0] == 4'hF) ? 4'hE : reg_wdata[3:0];
      if (wr_hr)
        supply_headroom_setting <= reg_wdata[4:0];
      if (wr_vmpo)
        peak_out_code <= reg_wdata[11:0];
    end
  end

  // ==========================================================
  // Target peak output and its attenuation
  // ==========================================================
  logic signed [4:0] hr_clamped;
  logic [5:0] hr_scale;
  logic [17:0] tpo_num;
  logic [17:0] mpo_num;
  hlc_db_t tpo_db;
  hlc_db_t mpo_db;
  logic signed [16:0] atpo_raw;
  hlc_db_t atpo_now;

  // Headroom beyond +-20 percent is held at the end of the range.
  assign hr_clamped = (supply_headroom_setting > $signed(`HLC_HR_MAX)) ? $signed(`HLC_HR_MAX) :
    (supply_headroom_setting < -$signed(`HLC_HR_MAX)) ? -$signed(`HLC_HR_MAX) :
    supply_headroom_setting;
  // Both sides are scaled by 40 so the headroom ratio needs no divide.
  assign hr_scale = `HLC_HR_FULL - 6'(hr_clamped);
  assign tpo_num = supply_code * hr_scale;
  assign mpo_num = peak_out_code * `HLC_HR_FULL;

  hlc_level_log u_tpo_log
  (
    .mag({6'h00, tpo_num}),
    .level_db(tpo_db)
  );

  hlc_level_log u_mpo_log
  (
    .mag({6'h00, mpo_num}),
    .level_db(mpo_db)
  );

  // Enough supply means no processing other than the fixed limiter: never a gain above unity.
  assign atpo_raw = 17'(tpo_db) - 17'(mpo_db);
  assign atpo_now = (atpo_raw > 17'sh00000) ? 16'sh0000 :
    (atpo_raw < -17'sh07FFF) ? -16'sh7FFF : atpo_raw[15:0];

  // ==========================================================
  // Thresholds and knees, all in dBFS
  // ==========================================================
  hlc_db_t knee_db;
  hlc_db_t fixed_thr_db;
  hlc_db_t lim_thr_db;
  logic comp_on;
  logic lim_on;

  // The knee is set relative to input full scale and never moves with supply.
  assign knee_db = -$signed({6'h00, compressor_knee_point, 6'h00});
  assign fixed_thr_db = -$signed({6'h00, level_limit_threshold, 6'h00});
  // The limiter follows the supply unless the fixed type is selected.
  assign lim_thr_db = limiter_type_select ? fixed_thr_db : atpo_now;
  // A knee at 0 dBFS switches the compressor off.
  assign comp_on = (compressor_knee_point != 4'h0);
  // A fixed threshold at 0 dBFS switches the limiter off.
  assign lim_on = !limiter_type_select || (level_limit_threshold != 4'h0);

  // ==========================================================
  // Compressor quotient and ratio
  // ==========================================================
  hlc_seq_e seq;
  hlc_seq_e next_seq;
  logic div_start;
  logic div_done;
  logic [15:0] div_num;
  logic [15:0] div_den;
  logic [15:0] div_quot;
  logic [15:0] comp_quot;
  logic [15:0] comp_ratio;
  logic [15:0] atpo_mag;
  logic [15:0] knee_mag;
  logic [15:0] span_mag;

  assign atpo_mag = 16'(-atpo_now);
  assign knee_mag = 16'(-knee_db);
  // Knee minus target, as a magnitude; the plain distance when the target sits past the knee.
  assign span_mag = (atpo_mag < knee_mag) ? 16'(knee_mag - atpo_mag) : 16'(atpo_mag - knee_mag);
  // Six fraction bits, so the numerator is shifted up; the divisor holds while a division runs.
  assign div_num = (seq == HLC_Q_START) ? {atpo_mag[9:0], 6'h00} : {knee_mag[9:0], 6'h00};
  assign div_den = ((seq == HLC_Q_START) || (seq == HLC_Q_WAIT)) ? knee_mag : span_mag;
  assign div_start = (seq == HLC_Q_START) || (seq == HLC_R_START);

  // The divider runs without pause so both figures track the supply.
  always_comb
  begin
    next_seq = seq;
    unique case (seq)
      HLC_Q_START: next_seq = HLC_Q_WAIT;
      HLC_Q_WAIT: if (div_done) next_seq = HLC_R_START;
      HLC_R_START: next_seq = HLC_R_WAIT;
      HLC_R_WAIT: if (div_done) next_seq = HLC_Q_START;
    endcase
  end

  hlc_divider u_div
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quot(div_quot)
  );

  // Sequencer state and the two latched results.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seq <= HLC_Q_START;
      comp_quot <= 16'h0000;
      comp_ratio <= 16'h0000;
    end
    else
    begin
      seq <= next_seq;
      if (div_done && (seq == HLC_Q_WAIT))
        comp_quot <= div_quot;
      if (div_done && (seq == HLC_R_WAIT))
        comp_ratio <= div_quot;
    end
  end

  // ==========================================================
  // Per-sample attenuation
  // ==========================================================
  logic s1_valid;
  logic signed [23:0] s1_sample;
  logic [23:0] s1_mag;
  hlc_db_t in_db;
  logic signed [16:0] lim_diff;
  logic [15:0] lim_att;
  logic signed [32:0] comp_prod;
  logic signed [26:0] comp_diff;
  logic [15:0] comp_att;
  logic [15:0] larger_att;
  logic [15:0] max_att;
  logic [9:0] next_atten;

  hlc_level_log u_in_log
  (
    .mag(s1_mag),
    .level_db(in_db)
  );

  // Limiter: nothing below its knee, then the full overshoot is removed.
  assign lim_diff = 17'(in_db) - 17'(lim_thr_db);
  assign lim_att = (lim_on && (lim_diff > 17'sh00000)) ? lim_diff[15:0] : 16'h0000;
  // Compressor: target minus input scaled by target over knee, as a magnitude.
  assign comp_prod = in_db * $signed({1'b0, comp_quot});
  assign comp_diff = comp_prod[32:6] - 27'(atpo_now);
  assign comp_att = (!comp_on || (in_db <= knee_db) || (comp_diff <= 27'sh0000000)) ? 16'h0000 :
    (comp_diff > 27'sh0007FFF) ? 16'h7FFF : comp_diff[15:0];
  // Compression comes first; the limiter only wins once it asks for more.
  assign larger_att = (lim_att > comp_att) ? lim_att : comp_att;
  assign max_att = {4'h0, 6'(max_attenuation_setting) + 6'h01, 6'h00};
  assign next_atten = !engine_enable ? 10'h000 :
    (larger_att > max_att) ? max_att[9:0] : larger_att[9:0];

  // Stage one takes the magnitude; the most negative sample folds to full scale.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_valid <= 1'b0;
      s1_sample <= 24'sh000000;
      s1_mag <= 24'h000000;
    end
    else
    begin
      s1_valid <= in_valid;
      if (in_valid)
      begin
        s1_sample <= in_sample;
        s1_mag <= in_sample[23] ? ((in_sample == 24'sh800000) ? 24'h7FFFFF : 24'(-in_sample))
          : in_sample;
      end
    end
  end

  // Stage two hands the sample on with the attenuation that belongs to it.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_sample <= 24'sh000000;
      out_atten <= 10'h000;
    end
    else
    begin
      out_valid <= s1_valid;
      if (s1_valid)
      begin
        out_sample <= s1_sample;
        out_atten <= next_atten;
      end
    end
  end

  // ==========================================================
  // Register read-back
  // ==========================================================
  logic [31:0] next_rdata;

  // Unmapped addresses read as zero; reads have no side effects.
  always_comb
  begin
    next_rdata = 32'h00000000;
    unique case (reg_addr)
      `HLC_OFS_CTRL: next_rdata = {30'h00000000, engine_enable, limiter_type_select};
      `HLC_OFS_LIMIT: next_rdata = {28'h0000000, level_limit_threshold};
      `HLC_OFS_KNEE: next_rdata = {28'h0000000, compressor_knee_point};
      `HLC_OFS_MAXATT: next_rdata = {28'h0000000, max_attenuation_setting};
      `HLC_OFS_HEADROOM: next_rdata = {27'h0000000, supply_headroom_setting};
      `HLC_OFS_VMPO: next_rdata = {20'h00000, peak_out_code};
      `HLC_OFS_ATPO: next_rdata = {{16{atpo_now[15]}}, atpo_now};
      `HLC_OFS_QUOT: next_rdata = {16'h0000, comp_quot};
      `HLC_OFS_RATIO: next_rdata = {16'h0000, comp_ratio};
      `HLC_OFS_ATTEN: next_rdata = {22'h000000, out_atten};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
  end

endmodule

// *** tb/hlc_core_properties.sv ***
`timescale 1ns/10ps
`include "hlc_consts.svh"
module hlc_core_props
(
  // Clock and reset.
  input logic core_clk,
  input logic resetn,
  // Register port.
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  // Stream and supply.
  input logic in_valid,
  input logic signed [23:0] in_sample,
  input logic [11:0] supply_code,
  input logic out_valid,
  input logic signed [23:0] out_sample,
  input logic [9:0] out_atten
);
  // ==========
  // Read tracking
  logic rd_q;
  logic [7:0] rd_a;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // Remember which place was read, so the answer can be judged.
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      rd_q <= 1'b0;
      rd_a <= 8'h00;
    end
    else
    begin
      rd_q <= reg_rd;
      rd_a <= reg_addr;
    end
  // ==========
  // Properties
  a_valid_delay: assert property (in_valid |-> ##2 out_valid)
    else $error("output strobe missing two cycles after a sample");
  a_sample_pass: assert property (out_valid |-> out_sample == $past(in_sample, 2))
    else $error("sample altered on its way through");
  a_hold_between: assert property (!out_valid |-> $stable(out_atten) && $stable(out_sample))
    else $error("output moved between samples");
  a_atten_cap: assert property (out_atten <= 10'h3C0)
    else $error("attenuation above the largest maximum");
  a_maxatt_fold: assert property (rd_q && rd_a == `HLC_OFS_MAXATT |->
    reg_rdata[3:0] != 4'hF && reg_rdata[31:4] == 28'h0)
    else $error("maximum code out of range");
  a_atpo_sign: assert property (rd_q && rd_a == `HLC_OFS_ATPO |->
    $signed(reg_rdata[15:0]) <= 0)
    else $error("target attenuation shows gain");
  a_knee_field: assert property (rd_q && rd_a == `HLC_OFS_KNEE |-> reg_rdata[31:4] == 28'h0)
    else $error("knee field too wide");
  a_limit_field: assert property (rd_q && rd_a == `HLC_OFS_LIMIT |-> reg_rdata[31:4] == 28'h0)
    else $error("threshold field too wide");
  a_zero_quiet: assert property (out_valid && $past(in_sample, 2) == 24'h0 &&
    supply_code[11:8] != 4'h0 |-> out_atten == 10'h0)
    else $error("silence was attenuated");
  // Main scenarios.
  c_atten: cover property (out_valid && out_atten != 10'h0);
  c_cap: cover property (out_valid && out_atten == 10'h0C0);
  c_atpo: cover property (rd_q && rd_a == `HLC_OFS_ATPO && reg_rdata != 32'h0);
endmodule
bind hlc_core hlc_core_props u_props (.core_clk(core_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .in_valid(in_valid), .in_sample(in_sample),
  .supply_code(supply_code), .out_valid(out_valid), .out_sample(out_sample),
  .out_atten(out_atten));

// *** tb/hlc_src_model.sv ***
`timescale 1ns/10ps
module hlc_src_model
(
  // Clock and reset.
  input logic core_clk,
  input logic resetn,
  // Bench requests.
  input logic send,
  input logic [23:0] smp,
  input logic [11:0] sup,
  // Towards the block.
  output logic in_valid,
  output logic signed [23:0] in_sample,
  output logic [11:0] supply_code
);
  // ==========
  // Sample path and supply converter
  // Between samples the data lines flip, so a block that samples late sees junk.
  // One supply code only, so no fast swap between two rails can occur.
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      in_valid <= 1'b0;
      in_sample <= 24'h000000;
      supply_code <= 12'h000;
    end
    else
    begin
      in_valid <= send;
      in_sample <= send ? smp : ~in_sample;
      supply_code <= sup;
    end
endmodule

// *** tb/headroom_limiter_compressor_tb.sv ***
`timescale 1ns/10ps
`include "hlc_consts.svh"
module headroom_limiter_compressor_tb;
  // ==========
  // Signals
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic send = 1'b0;
  logic [23:0] smp = 24'h0;
  logic [11:0] sup = 12'h000;
  logic [31:0] reg_rdata, rv, r;
  logic in_valid, out_valid;
  logic signed [23:0] in_sample, out_sample;
  logic [11:0] supply_code;
  logic [9:0] out_atten;
  int miscompares = 0;
  int n_checks = 0;
  int l, m;
  logic [7:0] ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h28};
  logic [31:0] rstv[7] = '{32'h0, 32'h0, 32'h0, 32'hE, 32'h0, 32'hFFF, 32'h0};
  logic [11:0] sp[3] = '{12'hFFF, 12'hC00, 12'h400};
  // Clock of 25 ns.
  always #12.5 core_clk = ~core_clk;
  hlc_core DUT (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_sample(in_sample), .supply_code(supply_code),
    .out_valid(out_valid), .out_sample(out_sample), .out_atten(out_atten));
  hlc_src_model SRC (.core_clk(core_clk), .resetn(resetn), .send(send), .smp(smp),
    .sup(sup), .in_valid(in_valid), .in_sample(in_sample), .supply_code(supply_code));
  // ==========
  // Checking and closing
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Levels come from a log estimate, so they are judged within a margin.
  task chk_att(input logic [15:0] got, input int exp, input int tol);
    integer d;
    n_checks++;
    d = $signed(got) - exp;
    if ((d > tol || d < -tol) !== 1'b0)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Level in 1/64 dB as the block estimates it: leading one plus a linear fraction.
  function automatic int ldb(int x);
    int p;
    p = 0;
    if (x == 0)
      return -32767;
    while ((x >> (p + 1)) != 0)
      p++;
    return ((p * 64 + ((x << (23 - p)) >> 17) % 64 - 1472) * 385) >>> 6;
  endfunction
  // Target attenuation in 1/64 dB; never above zero, since no gain is allowed.
  function automatic int atpo(int s, int v, int hr);
    int g;
    g = ldb(s * (40 - hr)) - ldb(v * 40);
    return g > 0 ? 0 : g;
  endfunction
  // Larger demand wins, then the maximum holds it.
  function automatic int att(int lim, int cmp, int mx);
    int a;
    a = lim > cmp ? lim : cmp;
    return a > (mx + 1) * 64 ? (mx + 1) * 64 : a;
  endfunction
  // ==========
  // Bus and stream tasks
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    rv = reg_rdata;
    @(posedge core_clk);
  endtask
  task put(input logic [23:0] x);
    int n;
    send <= 1'b1;
    smp <= x;
    @(posedge core_clk);
    send <= 1'b0;
    n = 0;
    @(negedge core_clk);
    while (out_valid !== 1'b1 && n < 8)
    begin
      @(negedge core_clk);
      n++;
    end
    chk_reg({31'h0, out_valid}, 32'h1);
    @(posedge core_clk);
  endtask
  // The quotient sequencer needs some tens of cycles to follow a change.
  task cfg(input logic [1:0] c, input logic [3:0] li, input logic [3:0] kn,
    input logic [3:0] mx, input logic [11:0] s);
    wr(`HLC_OFS_CTRL, {30'h0, c});
    wr(`HLC_OFS_LIMIT, {28'h0, li});
    wr(`HLC_OFS_KNEE, {28'h0, kn});
    wr(`HLC_OFS_MAXATT, {28'h0, mx});
    sup <= s;
    repeat (100) @(posedge core_clk);
  endtask
  // ==========
  // Main sequence; the attenuation start event is never relied on.
  initial
  begin
    void'($urandom(77));
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    foreach (ofs[i])
    begin
      rd(ofs[i]);
      chk_reg(rv, rstv[i]);
    end
    wr(8'h0C, 32'hF);
    rd(8'h0C);
    chk_reg(rv, 32'hE);
    cfg(2'h1, 4'h6, 4'h0, 4'hE, 12'hFFF);
    wr(8'h18, 32'h1234);
    rd(8'h18);
    chk_reg(rv, 32'h0);
    put(24'h7FFFFF);
    chk_att({6'h0, out_atten}, 0, 0);
    wr(8'h10, 32'h08);
    repeat (100) @(posedge core_clk);
    rd(8'h18);
    chk_att(rv[15:0], atpo(4095, 4095, 8), 8);
    wr(8'h10, 32'h18);
    repeat (100) @(posedge core_clk);
    rd(8'h18);
    chk_att(rv[15:0], atpo(4095, 4095, -8), 0);
    wr(8'h10, 32'h0);
    foreach (sp[i])
    begin
      cfg(2'h3, 4'h6, 4'h0, 4'hE, sp[i]);
      put(24'h7FFFFF);
      chk_att({6'h0, out_atten}, att(384, 0, 14), 40);
      put(24'h200000);
      chk_att({6'h0, out_atten}, 0, 0);
      put(24'h800001);
      chk_att({6'h0, out_atten}, 384, 40);
    end
    cfg(2'h3, 4'h6, 4'h0, 4'h2, 12'hFFF);
    put(24'h7FFFFF);
    chk_att({6'h0, out_atten}, att(384, 0, 2), 0);
    cfg(2'h2, 4'h0, 4'h0, 4'hE, 12'h800);
    put(24'h7FFFFF);
    chk_att({6'h0, out_atten}, -atpo(2048, 4095, 0), 40);
    put(24'h000000);
    chk_att({6'h0, out_atten}, 0, 0);
    cfg(2'h3, 4'h0, 4'h6, 4'hE, 12'hFFF);
    rd(8'h20);
    chk_reg(rv, 32'h40);
    rd(8'h1C);
    chk_reg(rv, 32'h0);
    put(24'h7FFFFF);
    chk_att({6'h0, out_atten}, 0, 0);
    cfg(2'h3, 4'h0, 4'h6, 4'hE, 12'h800);
    rd(8'h1C);
    chk_att(rv[15:0], 64, 4);
    put(24'h7FFFFF);
    chk_att({6'h0, out_atten}, att(0, -atpo(2048, 4095, 0), 14), 40);
    put(24'h200000);
    chk_att({6'h0, out_atten}, 0, 0);
    cfg(2'h3, 4'h3, 4'h6, 4'hE, 12'h800);
    put(24'h7FFFFF);
    chk_att({6'h0, out_atten}, att(192, 385, 14), 40);
    cfg(2'h3, 4'h3, 4'h6, 4'hE, 12'hFFF);
    put(24'h7FFFFF);
    chk_att({6'h0, out_atten}, att(192, 0, 14), 40);
    // Random thresholds, maxima and random levels somewhere below the threshold.
    repeat (30)
    begin
      l = 1 + $urandom % 15;
      m = $urandom % 15;
      cfg(2'h3, l[3:0], 4'h0, m[3:0], 12'hFFF);
      r = $urandom % (32'h7FFFFF >> (l / 6 + 1));
      if ($urandom % 2)
        r = -r;
      put(r[23:0]);
      chk_att({6'h0, out_atten}, 0, 0);
      put(24'h7FFFFF);
      chk_att({6'h0, out_atten}, att(l * 64, 0, m), 40);
    end
    close_out();
  end
  // Watchdog well beyond the expected run of some 5000 cycles.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
endmodule
